// ==== wdtrf_consts.svh ====
`ifndef WDTRF_CONSTS_SVH
`define WDTRF_CONSTS_SVH
// register addresses on the plain register port
`define WDTRF_ADDR_WDT_CTRL     4'h0
`define WDTRF_ADDR_RST_SRC      4'h1
`define WDTRF_ADDR_CORE_STATUS  4'h2
// watchdog control fields and reset value
`define WDTRF_WDT_CTRL_RESET    8'h53
`define WDTRF_KEY_DISABLE       5'h15
`define WDTRF_KEY_ENABLE        5'h0A
`define WDTRF_BASE_EXP          8
// reset source register bit positions
`define WDTRF_BIT_IDLE_KEEP     7
`define WDTRF_BIT_PIN_FAULT     3
`define WDTRF_BIT_LOW_VOLT      2
`define WDTRF_BIT_KEY_FAULT     0
// core status bit positions
`define WDTRF_BIT_TIMEOUT       1
`define WDTRF_BIT_POWER_DOWN    0
// key fault debounce: reset after 1~2 low-speed periods
`define WDTRF_KEY_FAULT_TICKS   2'h2
`endif

// ==== wdtrf_pkg.sv ====
package wdtrf_pkg;
    // run state of the core as seen by the watchdog
    typedef enum logic [1:0] {
        WDTRF_RUN,
        WDTRF_SLEEP,
        WDTRF_IDLE
    } wdtrf_mode_t;
endpackage

// ==== wdtrf_tick_sync.sv ====
// brings the low-speed oscillator clock into clk_i as a one-cycle tick
module wdtrf_tick_sync (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rstn_i,
    // low-speed clock level and its rising-edge tick
    input  wire logic lsc_i,
    output logic      tick_o
);
    logic sync1;      // first stage, read only by sync2
    logic sync2;      // second stage
    logic sync3;      // edge history
    logic next_sync1;
    logic next_sync2;
    logic next_sync3;

    // next values of the synchroniser chain
    always_comb begin
        next_sync1 = lsc_i;
        next_sync2 = sync1;
        next_sync3 = sync2;
    end

    // register the chain
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            sync3 <= 1'b0;
        end else begin
            sync1 <= next_sync1;
            sync2 <= next_sync2;
            sync3 <= next_sync3;
        end
    end

    // rising edge seen after the second stage only
    assign tick_o = sync2 & ~sync3;
endmodule

// ==== wdtrf_top.sv ====
// The placing of the registers and the address-and-strobe port were left to the implementer.
`include "wdtrf_consts.svh"
module wdtrf_top #(
    parameter int CNT_W = 16   // wide enough for 2^15 ticks
) (
    // clock and reset (rstn_i is the power-on reset)
    input  wire logic                  clk_i,
    input  wire logic                  rstn_i,
    // register port
    input  wire logic [3:0]            addr_i,
    input  wire logic [7:0]            wdata_i,
    input  wire logic                  wr_i,
    input  wire logic                  rd_i,
    output logic      [7:0]            rdata_o,
    // low-speed oscillator clock, sampled
    input  wire logic                  lsc_i,
    // core events and state
    input  wire logic                  clear_watchdog_instruction_i,
    input  wire logic                  halt_i,
    input  wire logic                  idle_en_i,
    input  wire logic                  wake_i,
    input  wire logic                  ext_rstn_i,
    input  wire logic                  low_volt_i,
    input  wire logic                  pin_cfg_fault_i,
    // reset requests and clock control
    output logic                       chip_rst_o,
    output logic                       warm_rst_o,
    output logic                       pc_sp_rst_o,
    output logic                       por_rst_o,
    output logic                       sys_clk_en_o,
    output logic                       wdt_running_o,
    output wdtrf_pkg::wdtrf_mode_t     mode_o
);
    import wdtrf_pkg::*;

    logic             tick;           // one-cycle low-speed tick
    logic [7:0]       wdt_ctrl;       // key field and timeout select
    logic [CNT_W-1:0] cnt;            // watchdog counter
    logic             key_fault;      // sticky key fault flag
    logic             pin_fault;      // sticky pin config fault flag
    logic             low_volt;       // sticky low voltage flag
    logic             idle_keep;      // keep system clock in idle
    logic             timeout_flag;   // status timeout flag
    logic             pd_flag;        // status power-down flag
    logic             kf_pend;        // bad key debounce running
    logic [1:0]       kf_cnt;         // debounce tick counter
    wdtrf_mode_t      mode;           // run, sleep or idle
    logic             por_done;       // first cycle after por seen
    logic [7:0]       next_wdt_ctrl;
    logic [CNT_W-1:0] next_cnt;
    logic             next_key_fault;
    logic             next_pin_fault;
    logic             next_low_volt;
    logic             next_idle_keep;
    logic             next_timeout_flag;
    logic             next_pd_flag;
    logic             next_kf_pend;
    logic [1:0]       next_kf_cnt;
    wdtrf_mode_t      next_mode;
    logic [7:0]       next_rdata;
    logic             next_por_done;
    logic [4:0]       key;            // current key field
    logic [2:0]       tsel;           // current timeout select
    logic             key_bad;        // key is neither valid pattern
    logic             wdt_on;         // watchdog counting
    logic             overflow;       // counter reached its limit
    logic [CNT_W-1:0] limit;          // ticks for selected timeout
    logic             kf_fire;        // debounce complete
    logic             ctrl_wr;        // write to control register

    // low-speed clock crossing
    wdtrf_tick_sync u_tick (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .lsc_i  (lsc_i),
        .tick_o (tick)
    );

    // decode of the control register
    always_comb begin
        key      = wdt_ctrl[7:3];
        tsel     = wdt_ctrl[2:0];
        key_bad  = (key != `WDTRF_KEY_DISABLE) &&
                   (key != `WDTRF_KEY_ENABLE);
        wdt_on   = (key == `WDTRF_KEY_ENABLE);
        // limit = 2^(8+n) - 1 so wrap happens after 2^(8+n) ticks
        limit    = CNT_W'((32'd1 << (`WDTRF_BASE_EXP + 32'(tsel)))
                          - 1);
        overflow = wdt_on && tick && (cnt == limit);
        kf_fire  = kf_pend && tick &&
                   (kf_cnt == `WDTRF_KEY_FAULT_TICKS - 2'h1);
        ctrl_wr  = wr_i && (addr_i == `WDTRF_ADDR_WDT_CTRL);
    end

    // next values of all control and status state
    always_comb begin
        next_wdt_ctrl     = wdt_ctrl;
        next_cnt          = cnt;
        next_key_fault    = key_fault;
        next_pin_fault    = pin_fault;
        next_low_volt     = low_volt;
        next_idle_keep    = idle_keep;
        next_timeout_flag = timeout_flag;
        next_pd_flag      = pd_flag;
        next_kf_pend      = kf_pend;
        next_kf_cnt       = kf_cnt;
        next_mode         = mode;
        next_rdata        = 8'h00;
        next_por_done     = 1'b1;
        // counter: clear events first, cleared while off, then hold or count
        if (!ext_rstn_i || clear_watchdog_instruction_i || halt_i || key_bad) begin
            next_cnt = '0;
        end else if (!wdt_on) begin
            next_cnt = '0;
        end else if (tick) begin
            next_cnt = overflow ? '0 : cnt + CNT_W'(1);
        end
        // bad key debounce: pending until the required ticks pass
        if (key_bad && !kf_pend) begin
            next_kf_pend = 1'b1;
            next_kf_cnt  = 2'h0;
        end else if (kf_pend && tick) begin
            next_kf_cnt = kf_cnt + 2'h1;
        end
        if (kf_fire) begin
            next_kf_pend  = 1'b0;
            next_wdt_ctrl = `WDTRF_WDT_CTRL_RESET;
        end
        // clear instruction and halt touch the status flags
        if (clear_watchdog_instruction_i) begin
            next_pd_flag = 1'b0;
        end
        if (halt_i) begin
            next_pd_flag      = 1'b1;
            next_timeout_flag = 1'b0;
            next_mode = idle_en_i ? WDTRF_IDLE : WDTRF_SLEEP;
        end else if (wake_i) begin
            next_mode = WDTRF_RUN;
        end
        // software writes: flags can only be cleared
        if (ctrl_wr) begin
            next_wdt_ctrl = wdata_i;
        end
        if (wr_i && addr_i == `WDTRF_ADDR_RST_SRC) begin
            next_idle_keep = wdata_i[`WDTRF_BIT_IDLE_KEEP];
            next_pin_fault = pin_fault &
                             wdata_i[`WDTRF_BIT_PIN_FAULT];
            next_low_volt  = low_volt &
                             wdata_i[`WDTRF_BIT_LOW_VOLT];
            next_key_fault = key_fault &
                             wdata_i[`WDTRF_BIT_KEY_FAULT];
        end
        // hardware sets win over a clearing write
        if (kf_fire) begin
            next_key_fault = 1'b1;
        end
        if (pin_cfg_fault_i) begin
            next_pin_fault = 1'b1;
        end
        if (low_volt_i) begin
            next_low_volt = 1'b1;
        end
        if (overflow) begin
            next_timeout_flag = 1'b1;
            next_mode         = WDTRF_RUN;                         // wakes core
        end
        // external pin reset: warm reset, control reloaded
        if (!ext_rstn_i) begin
            next_wdt_ctrl = `WDTRF_WDT_CTRL_RESET;
            next_mode     = WDTRF_RUN;
        end
        // read data, valid the cycle after the strobe
        if (rd_i) begin
            unique case (addr_i)
                `WDTRF_ADDR_WDT_CTRL:
                    next_rdata = wdt_ctrl;
                `WDTRF_ADDR_RST_SRC: begin
                    next_rdata = 8'h00;
                    next_rdata[`WDTRF_BIT_IDLE_KEEP] = idle_keep;
                    next_rdata[`WDTRF_BIT_PIN_FAULT] = pin_fault;
                    next_rdata[`WDTRF_BIT_LOW_VOLT]  = low_volt;
                    next_rdata[`WDTRF_BIT_KEY_FAULT] = key_fault;
                end
                `WDTRF_ADDR_CORE_STATUS: begin
                    next_rdata = 8'h00;
                    next_rdata[`WDTRF_BIT_TIMEOUT]    = timeout_flag;
                    next_rdata[`WDTRF_BIT_POWER_DOWN] = pd_flag;
                end
                default:
                    next_rdata = 8'h00;   // unmapped reads zero
            endcase
        end
    end

    // register everything; rstn_i is the power-on reset
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            wdt_ctrl     <= `WDTRF_WDT_CTRL_RESET;
            cnt          <= '0;
            key_fault    <= 1'b0;
            pin_fault    <= 1'b0;
            low_volt     <= 1'b0;
            idle_keep    <= 1'b0;
            timeout_flag <= 1'b0;
            pd_flag      <= 1'b0;
            kf_pend      <= 1'b0;
            kf_cnt       <= 2'h0;
            mode         <= WDTRF_RUN;
            rdata_o      <= 8'h00;
            por_done     <= 1'b0;
        end else begin
            wdt_ctrl     <= next_wdt_ctrl;
            cnt          <= next_cnt;
            key_fault    <= next_key_fault;
            pin_fault    <= next_pin_fault;
            low_volt     <= next_low_volt;
            idle_keep    <= next_idle_keep;
            timeout_flag <= next_timeout_flag;
            pd_flag      <= next_pd_flag;
            kf_pend      <= next_kf_pend;
            kf_cnt       <= next_kf_cnt;
            mode         <= next_mode;
            rdata_o      <= next_rdata;
            por_done     <= next_por_done;
        end
    end

    // reset requests to the rest of the chip
    always_comb begin
        // full reset on a key fault or an overflow while running
        chip_rst_o  = kf_fire || (overflow && mode == WDTRF_RUN);
        // in sleep or idle, the overflow only restarts pc and stack pointer
        pc_sp_rst_o = overflow && mode != WDTRF_RUN;
        // pin reset: a warm reset that spares some registers
        warm_rst_o  = !ext_rstn_i;
        // pc zero and ports high come from this strobe
        por_rst_o   = !por_done;
        // system clock runs unless asleep, or idle without keep
        sys_clk_en_o = (mode == WDTRF_RUN) ||
                       (mode == WDTRF_IDLE && idle_keep);
        wdt_running_o = wdt_on;
        mode_o        = mode;
    end
endmodule

// ==== wdtrf_checker.sv ====
`include "wdtrf_consts.svh"
// watches the watchdog block from its ports only
module wdtrf_checker (
    // clock and reset
    input wire logic                   clk_i,
    input wire logic                   rstn_i,
    // register port
    input wire logic [3:0]             addr_i,
    input wire logic [7:0]             wdata_i,
    input wire logic                   wr_i,
    input wire logic                   rd_i,
    input wire logic [7:0]             rdata_o,
    // core events and block outputs
    input wire logic                   halt_i,
    input wire logic                   idle_en_i,
    input wire logic                   ext_rstn_i,
    input wire logic                   chip_rst_o,
    input wire logic                   warm_rst_o,
    input wire logic                   pc_sp_rst_o,
    input wire logic                   por_rst_o,
    input wire logic                   sys_clk_en_o,
    input wire logic                   wdt_running_o,
    input wire wdtrf_pkg::wdtrf_mode_t mode_o
);
    import wdtrf_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // a control write carrying one key pattern
    sequence key_wr(logic [4:0] k);
        wr_i && addr_i == `WDTRF_ADDR_WDT_CTRL && wdata_i[7:3] == k;
    endsequence
    // a control write with neither valid key
    sequence bad_key_wr;
        wr_i && addr_i == `WDTRF_ADDR_WDT_CTRL
            && wdata_i[7:3] != `WDTRF_KEY_DISABLE
            && wdata_i[7:3] != `WDTRF_KEY_ENABLE;
    endsequence
    chk_key_off: assert property (key_wr(`WDTRF_KEY_DISABLE)
        |=> !wdt_running_o) else $error("still running after off key");
    chk_key_on: assert property (key_wr(`WDTRF_KEY_ENABLE)
        |=> wdt_running_o) else $error("not running after on key");
    // debounce: no reset for three cycles, then within a bounded wait
    chk_key_fault: assert property (bad_key_wr
        |=> !chip_rst_o [*3] ##[1:20] chip_rst_o)
        else $error("bad key reset timing");
    chk_read_quiet: assert property (!$past(rd_i)
        |-> rdata_o == 8'h00)
        else $error("read data outside read cycle");
    chk_warm_pin: assert property (warm_rst_o == !ext_rstn_i)
        else $error("pin reset not followed");
    chk_halt_mode: assert property (halt_i && mode_o == WDTRF_RUN
        |=> mode_o == ($past(idle_en_i) ? WDTRF_IDLE : WDTRF_SLEEP))
        else $error("halt entered wrong mode");
    chk_clock_gate: assert property (mode_o != WDTRF_IDLE
        |-> sys_clk_en_o == (mode_o == WDTRF_RUN))
        else $error("system clock enable wrong");
    chk_wake_reset: assert property (pc_sp_rst_o
        |-> mode_o != WDTRF_RUN && !chip_rst_o ##1 mode_o == WDTRF_RUN)
        else $error("sleep overflow reset wrong");
    chk_off_quiet: assert property (!wdt_running_o |-> !pc_sp_rst_o)
        else $error("overflow while disabled");
    chk_por_pulse: assert property ($rose(rstn_i)
        |-> por_rst_o ##1 !por_rst_o) else $error("power-on pulse wrong");
endmodule

bind wdtrf_top wdtrf_checker u_chk (
    .clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .halt_i(halt_i),
    .idle_en_i(idle_en_i), .ext_rstn_i(ext_rstn_i),
    .chip_rst_o(chip_rst_o), .warm_rst_o(warm_rst_o),
    .pc_sp_rst_o(pc_sp_rst_o), .por_rst_o(por_rst_o),
    .sys_clk_en_o(sys_clk_en_o), .wdt_running_o(wdt_running_o),
    .mode_o(mode_o)
);

// ==== tb_watchdog_timer_with_reset_flags.sv ====
`include "wdtrf_consts.svh"
module tb_watchdog_timer_with_reset_flags;
    timeunit 1ns;
    timeprecision 1ns;
    import wdtrf_pkg::*;
    localparam logic [3:0] CTRL = `WDTRF_ADDR_WDT_CTRL;
    localparam logic [3:0] SRC  = `WDTRF_ADDR_RST_SRC;
    localparam logic [3:0] STAT = `WDTRF_ADDR_CORE_STATUS;
    // stimulus, all driven right after a rising edge
    logic        clk_i = 0, rstn_i = 0, wr_i = 0, rd_i = 0, lsc_i = 0;
    logic        clear_watchdog_instruction_i = 0, halt_i = 0, idle_en_i = 0, wake_i = 0;
    logic        ext_rstn_i = 1, low_volt_i = 0, pin_cfg_fault_i = 0;
    logic [3:0]  addr_i = 4'h0;
    logic [7:0]  wdata_i = 8'h00;
    // block outputs
    logic [7:0]  rdata_o;
    logic        chip_rst_o, warm_rst_o, pc_sp_rst_o, por_rst_o;
    logic        sys_clk_en_o, wdt_running_o;
    wdtrf_mode_t mode_o;
    logic [1:0]  div = 2'h0;                  // low-speed clock divider
    int          errors = 0, checked = 0, cycles = 0;
    int          n, t;                        // cycles and ticks waited
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    // low-speed clock at a quarter rate keeps long timeouts cheap
    always @(posedge clk_i) begin
        div <= div + 2'h1;
        lsc_i <= div[1];
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            errors = errors + 1;
            final_report;
        end
    end
    wdtrf_top DUT (
        .clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .lsc_i(lsc_i),
        .clear_watchdog_instruction_i(clear_watchdog_instruction_i), .halt_i(halt_i), .idle_en_i(idle_en_i),
        .wake_i(wake_i), .ext_rstn_i(ext_rstn_i), .low_volt_i(low_volt_i),
        .pin_cfg_fault_i(pin_cfg_fault_i), .chip_rst_o(chip_rst_o),
        .warm_rst_o(warm_rst_o), .pc_sp_rst_o(pc_sp_rst_o),
        .por_rst_o(por_rst_o), .sys_clk_en_o(sys_clk_en_o),
        .wdt_running_o(wdt_running_o), .mode_o(mode_o)
    );
    task check(input logic ok, input string msg);
        checked = checked + 1;
        if (ok !== 1'b1) begin
            errors = errors + 1;
            $display("BAD %0t %s", $time, msg);
        end
    endtask
    // one-cycle register write
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    // one-cycle read, data judged in the following cycle only
    task rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 check(rdata_o === e, "read data");
    endtask
    task clr;
        @(posedge clk_i);
        clear_watchdog_instruction_i <= 1'b1;
        @(posedge clk_i);
        clear_watchdog_instruction_i <= 1'b0;
    endtask
    task halt(input logic idle);
        @(posedge clk_i);
        halt_i <= 1'b1;
        idle_en_i <= idle;
        @(posedge clk_i);
        halt_i <= 1'b0;
        #1;
    endtask
    // waits for either reset request, counting low-speed rises
    task wait_rst(input int lim);
        logic prev;
        prev = lsc_i;
        n = 0;
        t = 0;
        while (n < lim && chip_rst_o !== 1'b1 && pc_sp_rst_o !== 1'b1) begin
            @(posedge clk_i);
            #1;
            n = n + 1;
            if (lsc_i && !prev)
                t = t + 1;
            prev = lsc_i;
        end
    endtask
    task t_reset;
        rd(CTRL, `WDTRF_WDT_CTRL_RESET);
        rd(SRC, 8'h00);
        rd(STAT, 8'h00);
        rd(4'h3, 8'h00);
        check(wdt_running_o === 1'b1 &&
              sys_clk_en_o === 1'b1, "reset");
    endtask
    task t_flags;
        @(posedge clk_i);
        low_volt_i <= 1'b1;
        pin_cfg_fault_i <= 1'b1;
        @(posedge clk_i);
        low_volt_i <= 1'b0;
        pin_cfg_fault_i <= 1'b0;
        rd(SRC, 8'h0C);
        wr(SRC, 8'hFF);
        rd(SRC, 8'h8C);
        wr(SRC, 8'h00);
        rd(SRC, 8'h00);
        wr(STAT, 8'hFF);
        rd(STAT, 8'h00);
    endtask
    task t_key_fault;
        wr(CTRL, 8'hF8);
        wait_rst(40);
        check(chip_rst_o === 1'b1 && n >= 3 && n <= 16, "key fault");
        rd(SRC, 8'h01);
        rd(CTRL, 8'h53);
        wr(SRC, 8'h00);
        rd(SRC, 8'h00);
    endtask
    task t_disable;
        wr(CTRL, 8'hA8);
        #1 check(wdt_running_o === 1'b0, "disable");
        wait_rst(1200);
        check(n === 1200, "overflow while off");
        wr(CTRL, 8'h50);
        #1 check(wdt_running_o === 1'b1, "enable");
    endtask
    task t_overflow;
        int s;
        for (s = 0; s < 3; s++) begin
            wr(CTRL, {`WDTRF_KEY_ENABLE, s[2:0]});
            repeat (3) begin
                clr;
                wait_rst(2 * 2 ** (8 + s));
                check(chip_rst_o !== 1'b1, "reset despite clear");
            end
            clr;
            wait_rst(4 * 2 ** (8 + s) + 40);
            check(chip_rst_o === 1'b1, "no overflow");
            check(t >= 2 ** (8 + s) - 1 &&
                  t <= 2 ** (8 + s) + 1, "period");
            rd(STAT, 8'h02);
        end
    endtask
    task t_sleep;
        wr(CTRL, 8'h50);
        wr(SRC, 8'h00);
        halt(1'b0);
        check(mode_o === WDTRF_SLEEP &&
              sys_clk_en_o === 1'b0, "sleep");
        rd(STAT, 8'h01);
        wait_rst(1200);
        check(pc_sp_rst_o === 1'b1 && chip_rst_o === 1'b0, "wake");
        check(t >= 254 && t <= 257, "halt clear");
        rd(STAT, 8'h03);
        wr(SRC, 8'h80);
        halt(1'b1);
        check(mode_o === WDTRF_IDLE &&
              sys_clk_en_o === 1'b1, "idle");
        @(posedge clk_i);
        wake_i <= 1'b1;
        @(posedge clk_i);
        wake_i <= 1'b0;
        #1 check(mode_o === WDTRF_RUN, "wake source");
    endtask
    task t_pin;
        wr(CTRL, 8'h50);
        clr;
        repeat (400) @(posedge clk_i);
        ext_rstn_i <= 1'b0;
        @(posedge clk_i);
        #1 check(warm_rst_o === 1'b1, "pin reset");
        @(posedge clk_i);
        ext_rstn_i <= 1'b1;
        rd(CTRL, 8'h53);
        wr(CTRL, 8'h50);
        wait_rst(1200);
        check(chip_rst_o === 1'b1 &&
              t >= 250 && t <= 257, "pin clear");
    endtask
    task final_report;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        rstn_i <= 1'b1;
        t_reset;
        t_flags;
        t_key_fault;
        t_disable;
        t_overflow;
        t_sleep;
        t_pin;
        final_report;
    end
endmodule
